// ===== design/usbef_flags.sv
// endpoint event flags, shared endpoint mask, event lines and AHB-Lite register slave
`default_nettype none
`include "usbef_params.svh"
module usbef_flags (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [`USBEF_ADDR_W-1:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // endpoint engine events, one-cycle pulses; ep0_data_stage is a level that qualifies zlp_rx[0]
  input wire logic [`USBEF_NUM_EP-1:0] zlp_rx,
  input wire logic ep0_data_stage,
  input wire logic [`USBEF_NUM_EP-1:1] nak_tx,
  input wire logic [`USBEF_NUM_EP-1:1] xfer_done,
  // event lines
  output logic zlp_event,
  output logic nak_event,
  output logic ep_event,
  output logic irq
);
  import usbef_pkg::*;

  usbef_bus_req_t req;
  usbef_state_t s;
  usbef_state_t next_s;
  logic [`USBEF_NUM_EP-1:0] zlp_hit;
  logic [`USBEF_NUM_EP-1:0] nak_hit;
  logic [`USBEF_NUM_EP-1:0] done_hit;

  usbef_ahb_front u_front (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .haddr(haddr),
    .hready(hready),
    .req(req)
  );

  // zero wait states: the read word is taken from the post-write state,
  // so a read right behind a write to the same register sees the new value
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign zlp_event = s.zlp_out;
  assign nak_event = s.nak_out;
  assign ep_event = s.ep_out;
  assign irq = s.irq;

  always_comb begin
    next_s = s;
    // endpoint 0 only flags a zero-length packet of the data stage;
    // its status-stage packet is reported elsewhere
    zlp_hit = {zlp_rx[`USBEF_NUM_EP-1:1], zlp_rx[0] & ep0_data_stage};
    nak_hit = {nak_tx, 1'b0};
    done_hit = {xfer_done, 1'b0};
    // flags clear by writing 1; sets below win over a clear in the same cycle
    if (req.wr) begin
      unique case (req.wr_ofs)
        `USBEF_OFS_DONE: next_s.done = s.done & ~hwdata[`USBEF_NUM_EP-1:0];
        `USBEF_OFS_MASK: next_s.mask = hwdata[`USBEF_NUM_EP-1:0];
        `USBEF_OFS_ZLP: next_s.zlp = s.zlp & ~hwdata[`USBEF_NUM_EP-1:0];
        `USBEF_OFS_NAK: next_s.nak = s.nak & ~hwdata[`USBEF_NUM_EP-1:0];
        `USBEF_OFS_IRQ_MSK: next_s.irq_msk = hwdata[2:0];
        default: next_s.mask = s.mask;
      endcase
    end
    next_s.rdata = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.rd_ofs)
        `USBEF_OFS_DONE: next_s.rdata[`USBEF_NUM_EP-1:0] = next_s.done;
        `USBEF_OFS_MASK: next_s.rdata[`USBEF_NUM_EP-1:0] = next_s.mask;
        `USBEF_OFS_ZLP: next_s.rdata[`USBEF_NUM_EP-1:0] = next_s.zlp;
        `USBEF_OFS_NAK: next_s.rdata[`USBEF_NUM_EP-1:0] = next_s.nak;
        `USBEF_OFS_IRQ_ST: begin
          next_s.rdata[2:0] = s.irq_st;
          next_s.irq_st = `USBEF_RST_IRQ;
        end
        `USBEF_OFS_IRQ_MSK: next_s.rdata[2:0] = next_s.irq_msk;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    next_s.zlp = next_s.zlp | zlp_hit;
    next_s.nak = (next_s.nak | nak_hit) & `USBEF_EP0_KEEP;
    next_s.done = (next_s.done | done_hit) & `USBEF_EP0_KEEP;
    next_s.irq_st[`USBEF_IRQ_ZLP] = next_s.irq_st[`USBEF_IRQ_ZLP] | (|zlp_hit);
    next_s.irq_st[`USBEF_IRQ_NAK] = next_s.irq_st[`USBEF_IRQ_NAK] | (|nak_hit);
    next_s.irq_st[`USBEF_IRQ_DONE] = next_s.irq_st[`USBEF_IRQ_DONE] | (|done_hit);
    // mask bit 1 blocks the line but never stops the flag from setting
    next_s.zlp_out = |(s.zlp & ~s.mask);
    next_s.nak_out = |(s.nak & ~s.mask);
    next_s.ep_out = |(s.done & ~s.mask);
    next_s.irq = |(s.irq_st & ~s.irq_msk);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s.zlp <= `USBEF_RST_FLAGS;
      s.nak <= `USBEF_RST_FLAGS;
      s.done <= `USBEF_RST_FLAGS;
      s.mask <= `USBEF_RST_MASK;
      s.irq_st <= `USBEF_RST_IRQ;
      s.irq_msk <= `USBEF_RST_IRQ;
      s.zlp_out <= 1'b0;
      s.nak_out <= 1'b0;
      s.ep_out <= 1'b0;
      s.irq <= 1'b0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  zlp_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (zlp_rx[7:1] != 7'h00) |=>
      ((s.zlp[7:1] & $past(zlp_rx[7:1])) == $past(zlp_rx[7:1])))
    else $error("zero-length flag not set after reception");

  ep0_stage_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (zlp_rx[0] && !ep0_data_stage && !s.zlp[0]) |=> !s.zlp[0])
    else $error("endpoint 0 flag set outside data stage");

  nak_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (nak_tx != 7'h00) |=> (((s.nak[7:1] & $past(nak_tx)) == $past(nak_tx)) && !s.nak[0]))
    else $error("NAK flag not set or endpoint 0 NAK flag set");

  zlp_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((s.zlp & ~s.mask) != 8'h00) |=> zlp_event)
    else $error("unmasked zero-length flag not on its line");

  nak_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((s.nak & ~s.mask) == 8'h00) |=> !nak_event)
    else $error("NAK line high with no unmasked flag");

  zlp_masked_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s.zlp == 8'h00 && zlp_rx[7:1] != 7'h00 && (zlp_rx & ~s.mask) == 8'h00
      && !req.wr) |=> (s.zlp != 8'h00) ##1 !zlp_event)
    else $error("masked zero-length flag reached its line");

  nak_masked_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s.nak == 8'h00 && nak_tx != 7'h00 && (nak_tx & ~s.mask[7:1]) == 7'h00
      && !req.wr) |=> (s.nak != 8'h00) ##1 !nak_event)
    else $error("masked NAK flag reached its line");

  done_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(s.done & ~s.mask) != 8'h00) == ep_event)
    else $error("endpoint line does not follow unmasked flags");

  // each line is registered from the state one edge earlier, so flag and mask
  // changes show up a cycle late; these compare against that earlier state
  zlp_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(s.zlp & ~s.mask) != 8'h00) == zlp_event)
    else $error("zero-length line does not follow unmasked flags");

  nak_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(s.nak & ~s.mask) != 8'h00) == nak_event)
    else $error("NAK line does not follow unmasked flags");

  irq_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(s.irq_st & ~s.irq_msk) != 3'h0) == irq)
    else $error("interrupt does not follow unmasked status");

  zlp_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((s.zlp & ~s.mask) == 8'h00) |=> !zlp_event)
    else $error("zero-length line high with every flag masked");

  ep_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((s.done & ~s.mask) == 8'h00) |=> !ep_event)
    else $error("endpoint line high with every flag masked");

  ep0_data_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (zlp_rx[0] && ep0_data_stage) |=> s.zlp[0])
    else $error("endpoint 0 data-stage zero-length packet not flagged");

  ep0_none_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !s.nak[0] && !s.done[0])
    else $error("endpoint 0 NAK or completion flag set");

  // flags are sticky: only a register write may take a bit away
  zlp_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !req.wr |=> ((s.zlp & $past(s.zlp)) == $past(s.zlp)))
    else $error("zero-length flag lost without a write");

  nak_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !req.wr |=> ((s.nak & $past(s.nak)) == $past(s.nak)))
    else $error("NAK flag lost without a write");

  irq_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (nak_tx != 7'h00) |=> s.irq_st[`USBEF_IRQ_NAK])
    else $error("NAK event did not set its interrupt status");

  // hrdata stands for the data phase only and is zero otherwise
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !req.rd |=> (hrdata == 32'h0000_0000))
    else $error("read data not zero outside a read data phase");

endmodule : usbef_flags
`default_nettype wire

// ===== design/usbef_params.svh
// register offsets, field positions and reset values of the endpoint event flag block
`ifndef USBEF_PARAMS_SVH
`define USBEF_PARAMS_SVH

`define USBEF_NUM_EP 8
`define USBEF_ADDR_W 12

`define USBEF_OFS_DONE 12'h000
`define USBEF_OFS_MASK 12'h004
`define USBEF_OFS_ZLP 12'h008
`define USBEF_OFS_NAK 12'h00C
`define USBEF_OFS_IRQ_ST 12'h010
`define USBEF_OFS_IRQ_MSK 12'h014

`define USBEF_RST_FLAGS 8'h00
`define USBEF_RST_MASK 8'h00
`define USBEF_RST_IRQ 3'h0
`define USBEF_EP0_KEEP 8'hFE

`define USBEF_IRQ_ZLP 0
`define USBEF_IRQ_NAK 1
`define USBEF_IRQ_DONE 2

`endif

// ===== design/usbef_pkg.sv
// types shared by the endpoint event flag block
`default_nettype none
`include "usbef_params.svh"
package usbef_pkg;

  typedef struct packed {
    logic rd;
    logic [`USBEF_ADDR_W-1:0] rd_ofs;
    logic wr;
    logic [`USBEF_ADDR_W-1:0] wr_ofs;
  } usbef_bus_req_t;

  typedef struct packed {
    logic wr_pend;
    logic [`USBEF_ADDR_W-1:0] wr_ofs;
  } usbef_front_t;

  typedef struct packed {
    logic [`USBEF_NUM_EP-1:0] zlp;
    logic [`USBEF_NUM_EP-1:0] nak;
    logic [`USBEF_NUM_EP-1:0] done;
    logic [`USBEF_NUM_EP-1:0] mask;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
    logic zlp_out;
    logic nak_out;
    logic ep_out;
    logic irq;
    logic [31:0] rdata;
  } usbef_state_t;

endpackage : usbef_pkg
`default_nettype wire

// ===== design/usbef_ahb_front.sv
// AHB-Lite address and data phase tracking for the endpoint event flag block
`default_nettype none
`include "usbef_params.svh"
module usbef_ahb_front (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AHB-Lite address phase
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [`USBEF_ADDR_W-1:0] haddr,
  input wire logic hready,
  // decoded requests
  output usbef_pkg::usbef_bus_req_t req
);
  import usbef_pkg::*;

  usbef_front_t st;
  usbef_front_t next_st;
  logic take;

  // word aligned offset; sub-word address bits are ignored
  function automatic logic [`USBEF_ADDR_W-1:0] usbef_word_ofs(
    input logic [`USBEF_ADDR_W-1:0] a);
    usbef_word_ofs = {a[`USBEF_ADDR_W-1:2], 2'h0};
  endfunction : usbef_word_ofs

  always_comb begin
    take = hsel & hready & htrans[1];
    next_st.wr_pend = take & hwrite;
    next_st.wr_ofs = usbef_word_ofs(haddr);
    req.rd = take & ~hwrite;
    req.rd_ofs = usbef_word_ofs(haddr);
    // writes land in the data phase, when hwdata is valid
    req.wr = st.wr_pend;
    req.wr_ofs = st.wr_ofs;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : usbef_ahb_front
`default_nettype wire

// ===== bench/usbef_host_model.sv
// AHB-Lite master standing in for the processor side
`default_nettype none
`include "usbef_params.svh"
module usbef_host_model (
  // clock
  input wire logic core_clk,
  // AHB-Lite master
  output logic hsel = 1'b0,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [`USBEF_ADDR_W-1:0] haddr = '0,
  output logic [31:0] hwdata = 32'h0,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // one single word transfer; no cycle count assumed, waits on hready
  task automatic xfer(input logic w, input logic [`USBEF_ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask : xfer
endmodule : usbef_host_model
`default_nettype wire

// ===== bench/usbef_flags_tb_top.sv
// testbench of the endpoint event flag block
`default_nettype none
`include "usbef_params.svh"
module usbef_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [`USBEF_ADDR_W-1:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic [7:0] zlp_rx = 8'h00;
  logic ep0_data_stage = 1'b0;
  logic [7:1] nak_tx = 7'h00;
  logic [7:1] xfer_done = 7'h00;
  logic zlp_event, nak_event, ep_event, irq;
  int err_count = 0;
  int samples_checked = 0;

  always #25 core_clk = ~core_clk;
  assign hready = hreadyout;

  usbef_host_model i_usbef_host_model (.core_clk(core_clk), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .haddr(haddr),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  usbef_flags i_usbef_flags (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .haddr(haddr),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .zlp_rx(zlp_rx), .ep0_data_stage(ep0_data_stage),
    .nak_tx(nak_tx), .xfer_done(xfer_done), .zlp_event(zlp_event),
    .nak_event(nak_event), .ep_event(ep_event), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [`USBEF_ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_usbef_host_model.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask : rd

  // lines settle one edge after the register update
  task automatic wr(input logic [`USBEF_ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_usbef_host_model.xfer(1'b1, a, d, q);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : wr

  // one-cycle event pulses, then wait for the lines to follow
  task automatic ev(input logic [7:0] z, input logic ds, input logic [7:1] n,
                    input logic [7:1] x);
    @(posedge core_clk);
    zlp_rx <= z;
    ep0_data_stage <= ds;
    nak_tx <= n;
    xfer_done <= x;
    @(posedge core_clk);
    zlp_rx <= 8'h00;
    nak_tx <= 7'h00;
    xfer_done <= 7'h00;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : ev

  // order: zlp, nak, ep, irq
  task automatic lines(input logic [3:0] exp);
    chk({28'h0, zlp_event, nak_event, ep_event, irq}, {28'h0, exp});
  endtask : lines

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    lines(4'h0);
    for (int i = 0; i < 7; i++) rd(12'(4 * i), 32'h0);
    wr(`USBEF_OFS_MASK, 32'h02);
    rd(`USBEF_OFS_MASK, 32'h02);
    ev(8'h01, 1'b0, 7'h00, 7'h00);
    rd(`USBEF_OFS_ZLP, 32'h0);
    lines(4'h0);
    ev(8'h05, 1'b1, 7'h00, 7'h00);
    lines(4'b1001);
    rd(`USBEF_OFS_ZLP, 32'h05);
    ev(8'h00, 1'b0, 7'h7F, 7'h00);
    lines(4'b1101);
    rd(`USBEF_OFS_NAK, 32'hFE);
    ev(8'h00, 1'b0, 7'h00, 7'h07);
    lines(4'b1111);
    rd(`USBEF_OFS_DONE, 32'h0E);
    wr(`USBEF_OFS_DONE, 32'h0C);
    lines(4'b1101);
    rd(`USBEF_OFS_DONE, 32'h02);
    rd(`USBEF_OFS_IRQ_ST, 32'h07);
    repeat (2) @(posedge core_clk);
    #1;
    lines(4'b1100);
    rd(`USBEF_OFS_IRQ_ST, 32'h0);
    wr(`USBEF_OFS_MASK, 32'hFF);
    lines(4'h0);
    rd(`USBEF_OFS_ZLP, 32'h05);
    wr(`USBEF_OFS_NAK, 32'hFE);
    wr(`USBEF_OFS_ZLP, 32'hFF);
    rd(`USBEF_OFS_ZLP, 32'h0);
    ev(8'h02, 1'b0, 7'h01, 7'h00);
    rd(`USBEF_OFS_ZLP, 32'h02);
    rd(`USBEF_OFS_NAK, 32'h02);
    lines(4'b0001);
    wr(`USBEF_OFS_IRQ_MSK, 32'h07);
    lines(4'h0);
    rd(`USBEF_OFS_IRQ_MSK, 32'h07);
    wr(`USBEF_OFS_MASK, 32'h00);
    lines(4'b1110);
    report_and_stop();
  end

  // whole run needs about 120 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
endmodule : usbef_flags_tb_top
`default_nettype wire
